// File: afp_dc_detect.sv
/*
  DC offset qualifier: raises a level when either channel's duty stays
  above the limit at one polarity for longer than the qualification time.
  Assumes duty-over inputs are already synchronous to clock_i.
*/
`timescale 1ns/1ps
module afp_dc_detect #(
  parameter int unsigned QUAL_CYC = 4200000
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic [1:0] duty_pos_i,
  input wire logic [1:0] duty_neg_i,
  output logic dc_error_o
);
  localparam int unsigned CW = $clog2(QUAL_CYC + 2);
  logic [1:0][CW-1:0] cnt_ff;
  logic [1:0][CW-1:0] nxt_cnt;
  logic [1:0] pol_ff;
  logic [1:0] nxt_pol;
  logic dc_ff;
  logic nxt_dc;

  // Per channel: count while over-limit at one polarity, restart on flip
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_pol = pol_ff;
    nxt_dc = 1'b0;
    for (int c = 0; c < 2; c++) begin
      if (!(duty_pos_i[c] ^ duty_neg_i[c])) begin
        nxt_cnt[c] = '0;
      end else if (duty_pos_i[c] != pol_ff[c]) begin
        nxt_pol[c] = duty_pos_i[c];
        nxt_cnt[c] = CW'(1);
      end else if (cnt_ff[c] <= CW'(QUAL_CYC)) begin
        nxt_cnt[c] = cnt_ff[c] + CW'(1);
      end
      // Strictly longer than the qualification time
      if (nxt_cnt[c] > CW'(QUAL_CYC)) begin
        nxt_dc = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt_ff <= '0;
      pol_ff <= 2'h0;
      dc_ff <= 1'b0;
    end else if (enable_i) begin
      cnt_ff <= nxt_cnt;
      pol_ff <= nxt_pol;
      dc_ff <= nxt_dc;
    end
  end
  assign dc_error_o = dc_ff;

  a_dc_needs_time: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    $rose(dc_ff) |-> $past(cnt_ff[0]) >= CW'(QUAL_CYC)
      || $past(cnt_ff[1]) >= CW'(QUAL_CYC))
    else $error("dc error raised before qualification time");
endmodule

// File: afp_fault_mgr.sv
/*
  Amplifier fault protection manager: sorts error detections into
  latching and self-clearing, halts playback, drives the open-drain
  fault pin and holds per-error status bits.
  Assumes error and clock-monitor inputs are asynchronous pins; the
  shutdown control bit comes from logic on clock_i.
*/
`timescale 1ns/1ps
module afp_fault_mgr
  import afp_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = afp_pkg::FAULT_TIMEOUT_CYC,
  parameter int unsigned DC_QUAL = afp_pkg::DC_QUAL_CYC
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic amp_shutdown_n_i,
  input wire logic amp_shutdown_bit_i,
  input wire logic overvoltage_i,
  input wire logic undervoltage_i,
  input wire logic ratio_bad_i,
  input wire logic rate_bad_i,
  input wire logic clock_stopped_i,
  input wire logic overcurrent_i,
  input wire logic [1:0] duty_pos_i,
  input wire logic [1:0] duty_neg_i,
  input wire logic overtemp_i,
  input wire logic overtemp_hysteresis_i,
  output logic amp_fault_n_o,
  output logic amp_fault_n_oe_o,
  output logic play_o,
  output logic shutdown_o,
  output logic [afp_pkg::ST_W-1:0] status_o
);
  import afp_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_WAIT} afp_state_t;
  localparam int unsigned TW = $clog2(TIMEOUT_CYC + 1);

  logic [8:0] s1_ff;
  logic [8:0] s2_ff;
  logic sd_pin_ff;
  logic sd_ff;
  logic nxt_sd;
  afp_state_t state_ff;
  afp_state_t nxt_state;
  logic [TW-1:0] tmo_ff;
  logic [TW-1:0] nxt_tmo;
  logic [ST_W-1:0] status_ff;
  logic [ST_W-1:0] nxt_status;
  logic fault_ff;
  logic nxt_fault;
  logic play_ff;
  logic nxt_play;
  logic dc_err;
  logic ov, uv, clk_err, oc, ot, ot_hyst, sd_now;
  logic sd_rise, latch_hit, nonlatch_hit;

  // Two-flop synchronisers for all pin inputs
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s1_ff <= 9'h000;
      s2_ff <= 9'h000;
      sd_pin_ff <= 1'b0;
    end else if (clk_en_i) begin
      s1_ff <= {amp_shutdown_n_i, overvoltage_i, undervoltage_i,
                ratio_bad_i, rate_bad_i, clock_stopped_i,
                overcurrent_i, overtemp_i, overtemp_hysteresis_i};
      s2_ff <= s1_ff;
      sd_pin_ff <= s2_ff[8];
    end
  end

  assign ov = s2_ff[7];
  assign uv = s2_ff[6];
  assign clk_err = s2_ff[5] | s2_ff[4] | s2_ff[3];
  assign oc = s2_ff[2];
  assign ot = s2_ff[1];
  assign ot_hyst = s2_ff[0];
  // Either the pin or the control bit can hold shutdown
  assign sd_now = s2_ff[8] & sd_pin_ff & amp_shutdown_bit_i;
  assign sd_rise = sd_now & ~sd_ff;
  assign latch_hit = oc | dc_err | ot;
  assign nonlatch_hit = ov | uv | clk_err;

  // Duty masked while halted: a frozen detector would keep its own latch
  // alive forever, so the count and the error drop once playback stops
  afp_dc_detect #(
    .QUAL_CYC(DC_QUAL)
  ) u_dc (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .enable_i(clk_en_i),
    .duty_pos_i(duty_pos_i & {2{play_ff}}),
    .duty_neg_i(duty_neg_i & {2{play_ff}}),
    .dc_error_o(dc_err)
  );

  // Fault state machine and timeout counter
  always_comb begin
    nxt_state = state_ff;
    nxt_tmo = tmo_ff;
    nxt_sd = sd_now;
    nxt_status = status_ff;
    // Self-clearing bits follow their condition
    nxt_status[ST_OV] = ov;
    nxt_status[ST_UV] = uv;
    nxt_status[ST_CLK] = clk_err;
    if (tmo_ff != '0) begin
      nxt_tmo = tmo_ff - TW'(1);
    end
    case (state_ff)
      ST_RUN: begin
        if (sd_now && latch_hit) begin
          nxt_state = ST_LATCHED;
          nxt_tmo = TW'(TIMEOUT_CYC);
        end
      end
      ST_LATCHED: begin
        // Only a low-to-high shutdown toggle leaves this state
        if (sd_rise) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!sd_now) begin
          nxt_state = ST_LATCHED;
        end else if (latch_hit) begin
          // Still present after release: fault again
          nxt_state = ST_LATCHED;
          nxt_tmo = TW'(TIMEOUT_CYC);
        end else if (tmo_ff == '0 && ot_hyst) begin
          // Toggle done, timeout gone, temperature below hysteresis
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
    // Latched bits set on detection outside shutdown; cleared only on recovery
    if (nxt_state == ST_RUN && state_ff == ST_WAIT) begin
      nxt_status[ST_OC] = 1'b0;
      nxt_status[ST_DC] = 1'b0;
      nxt_status[ST_OT] = 1'b0;
    end
    if (sd_now) begin
      nxt_status[ST_OC] = nxt_status[ST_OC] | oc;
      nxt_status[ST_DC] = nxt_status[ST_DC] | dc_err;
      nxt_status[ST_OT] = nxt_status[ST_OT] | ot;
    end
    // Pin low for latched states, or for clock errors outside shutdown, only
    nxt_fault = (nxt_state != ST_RUN) | (clk_err & sd_now);
    nxt_play = sd_now & (nxt_state == ST_RUN) & ~nonlatch_hit;
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_RUN;
      tmo_ff <= '0;
      sd_ff <= 1'b0;
      status_ff <= ST_RESET;
      fault_ff <= 1'b0;
      play_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff <= nxt_state;
      tmo_ff <= nxt_tmo;
      sd_ff <= nxt_sd;
      status_ff <= nxt_status;
      fault_ff <= nxt_fault;
      play_ff <= nxt_play;
    end
  end

  // Open drain: drive only low, release otherwise
  assign amp_fault_n_o = 1'b0;
  assign amp_fault_n_oe_o = fault_ff;
  assign play_o = play_ff;
  assign shutdown_o = ~sd_ff;
  assign status_o = status_ff;

  a_fault_latched: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    state_ff != ST_RUN |-> fault_ff)
    else $error("latched fault without fault pin");
  a_no_play_latch: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    state_ff != ST_RUN |-> !play_ff)
    else $error("playing while latched");
  a_ov_silent: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (clk_en_i && state_ff == ST_RUN && !clk_err && sd_now)
      |=> !fault_ff || state_ff != ST_RUN)
    else $error("fault pin pulled for silent error");
  a_clk_pin_low: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (clk_en_i && clk_err && sd_now) |=> fault_ff)
    else $error("clock error without fault pin");
  a_latch_holds: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (clk_en_i && state_ff == ST_LATCHED && !sd_rise)
      |=> state_ff == ST_LATCHED)
    else $error("latched fault left without toggle");
  a_wait_timeout: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (state_ff == ST_WAIT && tmo_ff != '0)
      |=> state_ff != ST_RUN)
    else $error("recovered before timeout");
  a_ot_hyst_gate: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (clk_en_i && state_ff == ST_WAIT && !ot_hyst)
      |=> state_ff != ST_RUN)
    else $error("recovered without hysteresis");
  a_status_set: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (clk_en_i && sd_now && oc) |=> status_ff[ST_OC])
    else $error("overcurrent status not set");
  a_reenter: assert property (@(posedge clock_i)
    disable iff (!reset_n_i)
    (clk_en_i && state_ff == ST_WAIT && sd_now && latch_hit)
      |=> state_ff == ST_LATCHED && tmo_ff == TW'(TIMEOUT_CYC))
    else $error("no re-entry on persistent error");
  c_latch: cover property (@(posedge clock_i) state_ff == ST_LATCHED);
  c_recover: cover property (@(posedge clock_i)
    state_ff == ST_WAIT ##1 state_ff == ST_RUN);
  c_clk_err: cover property (@(posedge clock_i) clk_err && fault_ff);
  c_dc: cover property (@(posedge clock_i) dc_err);
endmodule

// File: afp_fault_mgr_bench.sv
/*
  Self-checking bench for the fault manager: table of self-clearing
  errors, then latching recovery, re-detection, hysteresis, DC and reset.
  Assumes shortened timeout and DC qualification parameters.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module afp_fault_mgr_bench;
  import afp_pkg::*;
  localparam int TO = 20;
  localparam int DQ = 50;
  logic clock_i = 0, reset_n_i = 0, sd_bit = 1, tog = 0;
  logic ov = 0, uv = 0, ratio = 0, rate = 0, stop = 0;
  logic oc = 0, ot = 0, hyst = 1, fault_n, oe, play, sd_out, sd_pin, seen;
  logic [1:0] dpos = 2'h0, dneg = 2'h0;
  logic [7:0] low_cyc = 8'h04;
  logic en = 1, auto = 0;
  logic [ST_W-1:0] st;
  int n_errors = 0, n_checks = 0, cyc = 0;
  // Errors {ov,uv,ratio,rate,stop}, then oe, play, status
  logic [12:0] rows [0:12] = '{
    {5'h00, 2'b01, 6'h00}, {5'h10, 2'b00, 6'h01}, {5'h00, 2'b01, 6'h00},
    {5'h08, 2'b00, 6'h02}, {5'h00, 2'b01, 6'h00}, {5'h04, 2'b10, 6'h04},
    {5'h00, 2'b01, 6'h00}, {5'h02, 2'b10, 6'h04}, {5'h00, 2'b01, 6'h00},
    {5'h01, 2'b10, 6'h04}, {5'h00, 2'b01, 6'h00}, {5'h18, 2'b00, 6'h03},
    {5'h00, 2'b01, 6'h00}};
  // Pull-up sets the level whenever the pin is released
  wire fault_line = oe ? fault_n : 1'b1;

  always #50 clock_i = ~clock_i;

  afp_fault_mgr #(.TIMEOUT_CYC(TO), .DC_QUAL(DQ)) i_dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .clk_en_i(en),
    .amp_shutdown_n_i(sd_pin), .amp_shutdown_bit_i(sd_bit),
    .overvoltage_i(ov), .undervoltage_i(uv), .ratio_bad_i(ratio),
    .rate_bad_i(rate), .clock_stopped_i(stop), .overcurrent_i(oc),
    .duty_pos_i(dpos), .duty_neg_i(dneg), .overtemp_i(ot),
    .overtemp_hysteresis_i(hyst), .amp_fault_n_o(fault_n),
    .amp_fault_n_oe_o(oe), .play_o(play), .shutdown_o(sd_out),
    .status_o(st));

  afp_host_model i_host (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .fault_line_i(fault_line),
    .toggle_i(tog), .auto_i(auto), .low_cyc_i(low_cyc),
    .amp_shutdown_n_o(sd_pin),
    .fault_seen_o(seen));

  task automatic step(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // Host pulls shutdown low for n cycles, then releases it
  task automatic host_toggle(input logic [7:0] n);
    @(negedge clock_i);
    low_cyc = n;
    tog = 1;
    @(negedge clock_i);
    tog = 0;
    step(int'(n) + 2);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      $display("timeout at cycle %0d", cyc);
      print_verdict();
    end
  end

  initial begin
    step(5);
    `CHK({oe, play, sd_out, st}, {3'b001, 6'h00});
    reset_n_i = 1;
    done("reset");
    for (int i = 0; i < 13; i++) begin
      step(1);
      {ov, uv, ratio, rate, stop} = rows[i][12:8];
      step(6);
      `CHK({oe, play, st}, rows[i][7:0]);
    end
    done("table");
    // Prompt toggle lands before the timeout has run out
    oc = 1;
    step(5);
    `CHK({fault_line, play, st[ST_OC]}, 3'b001);
    oc = 0;
    host_toggle(8'h04);
    step(2);
    `CHK(fault_line, 1'b0);
    step(TO + 5);
    `CHK({fault_line, play, st}, {2'b11, 6'h00});
    done("timeout");
    // No toggle: the latch must outlive the condition
    oc = 1;
    step(5);
    oc = 0;
    step(40);
    `CHK({oe, st[ST_OC], seen}, 3'b111);
    host_toggle(8'h0A);
    step(8);
    `CHK({fault_line, play, st}, {2'b11, 6'h00});
    done("persist");
    // Control bit toggle with the error still present
    oc = 1;
    step(5);
    sd_bit = 0;
    step(4);
    `CHK(sd_out, 1'b1);
    sd_bit = 1;
    step(TO + 10);
    `CHK({oe, play, sd_out, st[ST_OC]}, 4'b1001);
    oc = 0;
    host_toggle(8'h04);
    step(TO + 5);
    `CHK({fault_line, play, st}, {2'b11, 6'h00});
    done("redetect");
    // Overtemperature waits for the hysteresis indication
    ot = 1;
    hyst = 0;
    step(5);
    `CHK({oe, st[ST_OT]}, 2'b11);
    ot = 0;
    host_toggle(8'h04);
    step(TO + 5);
    `CHK({oe, play}, 2'b10);
    hyst = 1;
    step(6);
    `CHK({fault_line, play, st}, {2'b11, 6'h00});
    done("overtemp");
    // DC duty held over the limit past the qualification time
    dpos = 2'h1;
    step(DQ - 10);
    `CHK({oe, st[ST_DC]}, 2'b00);
    step(20);
    `CHK({oe, play, st[ST_DC]}, 3'b101);
    dpos = 2'h0;
    host_toggle(8'h04);
    step(TO + 5);
    `CHK({fault_line, play, st}, {2'b11, 6'h00});
    done("dc");
    // Enable low freezes pin sampling; the error shows once it runs
    en = 0;
    ov = 1;
    step(6);
    `CHK({oe, play, st}, {2'b01, 6'h00});
    en = 1;
    step(6);
    `CHK({oe, play, st}, {2'b00, 6'h01});
    ov = 0;
    step(6);
    `CHK({oe, play, st}, {2'b01, 6'h00});
    done("enable");
    // Fault looped back to shutdown recovers a latch with no host action
    auto = 1;
    oc = 1;
    step(5);
    oc = 0;
    step(TO + 20);
    `CHK({fault_line, play, st}, {2'b11, 6'h00});
    auto = 0;
    done("loopback");
    // Reset in mid-latch wipes status and releases the pin
    oc = 1;
    step(5);
    oc = 0;
    reset_n_i = 0;
    step(2);
    `CHK({oe, play, st}, {2'b00, 6'h00});
    reset_n_i = 1;
    step(6);
    `CHK({oe, play}, 2'b01);
    done("midreset");
    print_verdict();
  end
endmodule

// File: afp_host_model.sv
/*
  Host controller model for the fault manager: watches the fault line
  and drives the shutdown pin, toggling it low then high on request.
  In auto mode each new fault toggles shutdown by itself, as when the
  fault line is wired back to the shutdown pin.
  Assumes the bench resolves the open-drain fault wire with a pull-up.
*/
`timescale 1ns/1ps
module afp_host_model (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic fault_line_i,
  input wire logic toggle_i,
  input wire logic auto_i,
  input wire logic [7:0] low_cyc_i,
  output logic amp_shutdown_n_o,
  output logic fault_seen_o
);
  logic [7:0] cnt_ff;

  // Shutdown held low for low_cyc_i cycles, then released high
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      amp_shutdown_n_o <= 1'b1;
      cnt_ff <= 8'h00;
    end else if (toggle_i || (auto_i && !fault_line_i && !fault_seen_o)) begin
      // Auto mode fires once on the falling fault line
      amp_shutdown_n_o <= 1'b0;
      cnt_ff <= low_cyc_i;
    end else if (cnt_ff > 8'h01) begin
      cnt_ff <= cnt_ff - 8'h01;
    end else if (cnt_ff == 8'h01) begin
      cnt_ff <= 8'h00;
      amp_shutdown_n_o <= 1'b1;
    end
  end

  // Host notes a fault only from the resolved wire, not the enable
  always_ff @(posedge clock_i) begin
    fault_seen_o <= ~fault_line_i;
  end
endmodule

// File: afp_pkg.sv
/*
  Package for the amplifier fault protection manager: status bit
  positions, timing figures and derived cycle counts.
  Assumes a 10 MHz device clock.
*/
package afp_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  // Timeout figure in microseconds; the real value is a system choice
  localparam int unsigned FAULT_TIMEOUT_US = 1000;
  localparam int unsigned FAULT_TIMEOUT_CYC =
    (FAULT_TIMEOUT_US * (CLK_HZ / 1_000_000) > 0) ?
    FAULT_TIMEOUT_US * (CLK_HZ / 1_000_000) : 1;
  // DC qualification time in milliseconds, rounded down to whole cycles
  localparam int unsigned DC_QUAL_MS = 420;
  localparam int unsigned DC_QUAL_CYC = DC_QUAL_MS * (CLK_HZ / 1000);
  // Duty-cycle limit in percent; compared by the external duty detector
  localparam int unsigned DC_DUTY_LIMIT_PCT = 60;
  // Status bit positions
  localparam int unsigned ST_OV = 0;
  localparam int unsigned ST_UV = 1;
  localparam int unsigned ST_CLK = 2;
  localparam int unsigned ST_OC = 3;
  localparam int unsigned ST_DC = 4;
  localparam int unsigned ST_OT = 5;
  localparam int unsigned ST_W = 6;
  localparam logic [5:0] ST_RESET = 6'h00;
endpackage
